// ===== src/ast_pkg.sv
// Package with register map, field positions, reset values and timing counts of the sweep control.
package ast_pkg;

	// ************************************************************
	// Register offsets (word index on the register port)
	// ************************************************************
	localparam logic [3:0] OFF_CTRL0  = 4'h0;
	localparam logic [3:0] OFF_CTRL1  = 4'h1;
	localparam logic [3:0] OFF_CTRL2  = 4'h2;
	localparam logic [3:0] OFF_CTRL3  = 4'h3;
	localparam logic [3:0] OFF_CTRL4  = 4'h4;
	localparam logic [3:0] OFF_STATUS = 4'h5;
	localparam logic [3:0] OFF_RESULT = 4'h8;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int POS_START      = 0;
	localparam int POS_TRIG_MODE  = 1;
	localparam int POS_REPEAT     = 2;
	localparam int POS_CHAN       = 3;
	localparam int POS_RES10      = 0;
	localparam int POS_EXT_SEL    = 1;
	localparam int POS_SAMPLE     = 0;
	localparam int POS_HW_SEL     = 1;
	localparam int POS_PIN_GROUP  = 2;
	localparam int POS_DMA        = 0;
	localparam int POS_MULTIPORT  = 1;
	localparam int POS_GROUP_SEL  = 0;
	localparam int POS_BUSY       = 0;
	localparam int POS_INDEX      = 1;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [15:0] RST_CTRL0 = 16'h0000;
	localparam logic [15:0] RST_CTRL1 = 16'h0000;
	localparam logic [15:0] RST_CTRL2 = 16'h0000;
	localparam logic [15:0] RST_CTRL3 = 16'h0000;
	localparam logic [15:0] RST_CTRL4 = 16'h0000;

	// ************************************************************
	// Encodings
	// ************************************************************
	localparam logic [1:0] EXT_NONE  = 2'h0;
	localparam logic [1:0] EXT_ZERO  = 2'h1;
	localparam logic [1:0] EXT_ONE   = 2'h2;
	localparam logic [1:0] EXT_OPAMP = 2'h3;

	localparam logic [1:0] SRC_MAIN   = 2'h0;
	localparam logic [1:0] SRC_SECOND = 2'h1;
	localparam logic [1:0] SRC_EXT0   = 2'h2;
	localparam logic [1:0] SRC_EXT1   = 2'h3;

	localparam logic [3:0] SWEEP_LAST = 4'hF;

	// ************************************************************
	// Conversion lengths in converter clock cycles
	// ************************************************************
	localparam logic [5:0] CYC_SH_8    = 6'd28;
	localparam logic [5:0] CYC_SH_10   = 6'd33;
	localparam logic [5:0] CYC_PLAIN_8  = 6'd40;
	localparam logic [5:0] CYC_PLAIN_10 = 6'd49;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_CONV = 3'b100
	} ast_state_t;

endpackage

// ===== src/ast_result_mem.sv
// Eight-word result store with a registered read port for the register bus.
module ast_result_mem (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset,
	// Write side
	input  wire logic        wr_en,
	input  wire logic [2:0]  wr_addr,
	input  wire logic [9:0]  wr_data,
	// Read side
	input  wire logic        rd_en,
	input  wire logic        rd_mem,
	input  wire logic [2:0]  rd_addr,
	input  wire logic [15:0] side_data,
	output logic      [15:0] rd_data
);

	logic [9:0] mem [0:7];

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < 8; i++) begin
				mem[i] <= 10'h000;
			end
		end else if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// The bus read data are only valid in the cycle after the strobe, zero elsewhere.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rd_data <= 16'h0000;
		end else if (rd_en && rd_mem) begin
			rd_data <= {6'h00, mem[rd_addr]};
		end else if (rd_en) begin
			rd_data <= side_data;
		end else begin
			rd_data <= 16'h0000;
		end
	end

endmodule

// ===== src/ast_sweep_trigger_control.sv
// Converter sweep, trigger and result placement control with its register port.
// How it works
// - Multi-port sweep converts main channels 0-7, then selected group channels 0-7.
// - Sweep wraps from index 15 to 0 continuously; group select goes out unchanged.
// - Sweeping stops as soon as software writes the start bit to zero.
// - Each completed channel conversion raises an interrupt request pulse.
// - Ten-bit mode stores bits 9-0; eight-bit mode stores bits 9-2 as bits 7-0, upper zero.
// - With sample-hold, conversion takes 28 cycles at 8 bits, 33 at 10.
// - Software trigger mode begins converting once the start bit is one.
// - External mode starts on a falling edge of the trigger pin.
// - Hardware mode starts on the motor timer counter event.
// - Triggered modes need the start bit at one before the event counts.
// - A trigger during conversion aborts it and restarts from the beginning.
// - In DMA mode every result lands in register zero with a transfer request.
// - Outside multi-port sweep the two extended inputs can be conversion sources.
// - Extended select 00 none, 01 extended input zero, 10 extended input one.
// - Extended zero result to register zero; extended one to one, or zero in DMA.
// - Op-amp mode routes channel out on input zero, converts input one, own register.
module ast_sweep_trigger_control (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset,
	// Register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// Trigger sources
	input  wire logic        external_trigger_input,
	input  wire logic        motor_timer_counter,
	// Converter core
	input  wire logic [9:0]  core_result,
	output logic      [1:0]  input_source,
	output logic      [1:0]  input_group,
	output logic      [2:0]  input_channel,
	output logic             extended_input_zero_drive,
	output logic             converting,
	// Requests
	output logic             irq_req,
	output logic             dma_req
);

	// ************************************************************
	// Control registers
	// ************************************************************
	logic       conversion_start_bit;
	logic       trigger_mode_select;
	logic       repeat_mode;
	logic [2:0] channel_select;
	logic       resolution_10;
	logic [1:0] extended_select;
	logic       sample_hold_enable;
	logic       hardware_trigger_select;
	logic [1:0] pin_group_select;
	logic       dma_mode_enable;
	logic       multiport_sweep_enable;
	logic [1:0] multiport_group_sel;

	logic wr_ctrl0;
	logic one_shot_end;
	logic conv_done;

	assign wr_ctrl0     = reg_wr && (reg_addr == ast_pkg::OFF_CTRL0);
	assign one_shot_end = conv_done && !multiport_sweep_enable && !repeat_mode;

	// A software write in the same cycle as the one-shot clear wins.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			conversion_start_bit <= ast_pkg::RST_CTRL0[ast_pkg::POS_START];
			trigger_mode_select  <= ast_pkg::RST_CTRL0[ast_pkg::POS_TRIG_MODE];
			repeat_mode          <= ast_pkg::RST_CTRL0[ast_pkg::POS_REPEAT];
			channel_select       <= ast_pkg::RST_CTRL0[ast_pkg::POS_CHAN +: 3];
		end else if (wr_ctrl0) begin
			conversion_start_bit <= reg_wdata[ast_pkg::POS_START];
			trigger_mode_select  <= reg_wdata[ast_pkg::POS_TRIG_MODE];
			repeat_mode          <= reg_wdata[ast_pkg::POS_REPEAT];
			channel_select       <= reg_wdata[ast_pkg::POS_CHAN +: 3];
		end else if (one_shot_end) begin
			conversion_start_bit <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			resolution_10           <= ast_pkg::RST_CTRL1[ast_pkg::POS_RES10];
			extended_select         <= ast_pkg::RST_CTRL1[ast_pkg::POS_EXT_SEL +: 2];
			sample_hold_enable      <= ast_pkg::RST_CTRL2[ast_pkg::POS_SAMPLE];
			hardware_trigger_select <= ast_pkg::RST_CTRL2[ast_pkg::POS_HW_SEL];
			pin_group_select        <= ast_pkg::RST_CTRL2[ast_pkg::POS_PIN_GROUP +: 2];
			dma_mode_enable         <= ast_pkg::RST_CTRL3[ast_pkg::POS_DMA];
			multiport_sweep_enable  <= ast_pkg::RST_CTRL3[ast_pkg::POS_MULTIPORT];
			multiport_group_sel     <= ast_pkg::RST_CTRL4[ast_pkg::POS_GROUP_SEL +: 2];
		end else if (reg_wr) begin
			unique case (reg_addr)
				ast_pkg::OFF_CTRL1: begin
					resolution_10   <= reg_wdata[ast_pkg::POS_RES10];
					extended_select <= reg_wdata[ast_pkg::POS_EXT_SEL +: 2];
				end
				ast_pkg::OFF_CTRL2: begin
					sample_hold_enable      <= reg_wdata[ast_pkg::POS_SAMPLE];
					hardware_trigger_select <= reg_wdata[ast_pkg::POS_HW_SEL];
					pin_group_select        <= reg_wdata[ast_pkg::POS_PIN_GROUP +: 2];
				end
				ast_pkg::OFF_CTRL3: begin
					dma_mode_enable        <= reg_wdata[ast_pkg::POS_DMA];
					multiport_sweep_enable <= reg_wdata[ast_pkg::POS_MULTIPORT];
				end
				ast_pkg::OFF_CTRL4: begin
					multiport_group_sel <= reg_wdata[ast_pkg::POS_GROUP_SEL +: 2];
				end
				default: begin
				end
			endcase
		end
	end

	// ************************************************************
	// Trigger detection
	// ************************************************************
	logic ext_meta;
	logic ext_sync;
	logic ext_prev;
	logic ext_fall;
	logic trig_event;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ext_meta <= 1'b1;
			ext_sync <= 1'b1;
			ext_prev <= 1'b1;
		end else begin
			ext_meta <= external_trigger_input;
			ext_sync <= ext_meta;
			ext_prev <= ext_sync;
		end
	end

	assign ext_fall   = ext_prev && !ext_sync;
	assign trig_event = trigger_mode_select &&
		(hardware_trigger_select ? motor_timer_counter : ext_fall);

	// ************************************************************
	// Sequencer
	// ************************************************************
	function automatic logic [5:0] conv_length(input logic sh, input logic ten);
		if (sh) begin
			conv_length = ten ? ast_pkg::CYC_SH_10 : ast_pkg::CYC_SH_8;
		end else begin
			conv_length = ten ? ast_pkg::CYC_PLAIN_10 : ast_pkg::CYC_PLAIN_8;
		end
	endfunction

	ast_pkg::ast_state_t state;
	ast_pkg::ast_state_t next_state;
	logic [5:0]          cycle_left;
	logic [3:0]          sweep_index;
	logic                begin_conv;

	always_comb begin
		next_state = state;
		begin_conv = 1'b0;
		unique case (state)
			ast_pkg::ST_IDLE: begin
				if (conversion_start_bit && !trigger_mode_select) begin
					begin_conv = 1'b1;
					next_state = ast_pkg::ST_CONV;
				end else if (conversion_start_bit) begin
					next_state = ast_pkg::ST_WAIT;
				end
			end
			ast_pkg::ST_WAIT: begin
				if (!conversion_start_bit) begin
					next_state = ast_pkg::ST_IDLE;
				end else if (trig_event) begin
					begin_conv = 1'b1;
					next_state = ast_pkg::ST_CONV;
				end
			end
			ast_pkg::ST_CONV: begin
				if (!conversion_start_bit) begin
					next_state = ast_pkg::ST_IDLE;
				end else if (trig_event) begin
					begin_conv = 1'b1;
				end else if (one_shot_end) begin
					next_state = ast_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = ast_pkg::ST_IDLE;
			end
		endcase
	end

	assign conv_done = (state == ast_pkg::ST_CONV) && conversion_start_bit &&
		!trig_event && (cycle_left == 6'd0);

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state <= ast_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cycle_left <= 6'd0;
		end else if (begin_conv || conv_done) begin
			cycle_left <= conv_length(sample_hold_enable, resolution_10) - 6'd1;
		end else if (state == ast_pkg::ST_CONV) begin
			cycle_left <= cycle_left - 6'd1;
		end
	end

	// The index wraps by its own width, so index 15 is followed by 0.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			sweep_index <= 4'h0;
		end else if (begin_conv) begin
			sweep_index <= 4'h0;
		end else if (conv_done && multiport_sweep_enable) begin
			sweep_index <= sweep_index + 4'h1;
		end
	end

	// ************************************************************
	// Input routing and result placement
	// ************************************************************
	logic [2:0] dest_reg;
	logic [9:0] placed_result;

	always_comb begin
		if (dma_mode_enable) begin
			dest_reg = 3'd0;
		end else if (multiport_sweep_enable) begin
			dest_reg = sweep_index[2:0];
		end else if (extended_select == ast_pkg::EXT_ZERO) begin
			dest_reg = 3'd0;
		end else if (extended_select == ast_pkg::EXT_ONE) begin
			dest_reg = 3'd1;
		end else begin
			dest_reg = channel_select;
		end
	end

	assign placed_result = resolution_10 ? core_result : {2'h0, core_result[9:2]};

	// Routing lags the sequencer by one cycle; the core samples only at the end.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			input_source              <= ast_pkg::SRC_MAIN;
			input_group               <= 2'h0;
			input_channel             <= 3'h0;
			extended_input_zero_drive <= 1'b0;
		end else if (multiport_sweep_enable) begin
			input_source              <= sweep_index[3] ? ast_pkg::SRC_SECOND : ast_pkg::SRC_MAIN;
			input_group               <= multiport_group_sel;
			input_channel             <= sweep_index[2:0];
			extended_input_zero_drive <= 1'b0;
		end else begin
			unique case (extended_select)
				ast_pkg::EXT_ZERO:  input_source <= ast_pkg::SRC_EXT0;
				ast_pkg::EXT_ONE:   input_source <= ast_pkg::SRC_EXT1;
				ast_pkg::EXT_OPAMP: input_source <= ast_pkg::SRC_EXT1;
				default:            input_source <= ast_pkg::SRC_MAIN;
			endcase
			input_group               <= pin_group_select;
			input_channel             <= channel_select;
			extended_input_zero_drive <= (extended_select == ast_pkg::EXT_OPAMP);
		end
	end

	// ************************************************************
	// Requests and status
	// ************************************************************
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			irq_req    <= 1'b0;
			dma_req    <= 1'b0;
			converting <= 1'b0;
		end else begin
			irq_req    <= conv_done;
			dma_req    <= conv_done && dma_mode_enable;
			converting <= (next_state == ast_pkg::ST_CONV);
		end
	end

	// ************************************************************
	// Register read path
	// ************************************************************
	logic [15:0] ctrl_read;

	always_comb begin
		ctrl_read = 16'h0000;
		unique case (reg_addr)
			ast_pkg::OFF_CTRL0: begin
				ctrl_read[ast_pkg::POS_START]      = conversion_start_bit;
				ctrl_read[ast_pkg::POS_TRIG_MODE]  = trigger_mode_select;
				ctrl_read[ast_pkg::POS_REPEAT]     = repeat_mode;
				ctrl_read[ast_pkg::POS_CHAN +: 3]  = channel_select;
			end
			ast_pkg::OFF_CTRL1: begin
				ctrl_read[ast_pkg::POS_RES10]       = resolution_10;
				ctrl_read[ast_pkg::POS_EXT_SEL +: 2] = extended_select;
			end
			ast_pkg::OFF_CTRL2: begin
				ctrl_read[ast_pkg::POS_SAMPLE]         = sample_hold_enable;
				ctrl_read[ast_pkg::POS_HW_SEL]         = hardware_trigger_select;
				ctrl_read[ast_pkg::POS_PIN_GROUP +: 2] = pin_group_select;
			end
			ast_pkg::OFF_CTRL3: begin
				ctrl_read[ast_pkg::POS_DMA]       = dma_mode_enable;
				ctrl_read[ast_pkg::POS_MULTIPORT] = multiport_sweep_enable;
			end
			ast_pkg::OFF_CTRL4: ctrl_read[ast_pkg::POS_GROUP_SEL +: 2] = multiport_group_sel;
			ast_pkg::OFF_STATUS: begin
				ctrl_read[ast_pkg::POS_BUSY]       = (state == ast_pkg::ST_CONV);
				ctrl_read[ast_pkg::POS_INDEX +: 4] = sweep_index;
			end
			default: ctrl_read = 16'h0000;
		endcase
	end

	ast_result_mem u_result_mem (
		.sys_clk   (sys_clk),
		.reset     (reset),
		.wr_en     (conv_done),
		.wr_addr   (dest_reg),
		.wr_data   (placed_result),
		.rd_en     (reg_rd),
		.rd_mem    (reg_addr[3] == ast_pkg::OFF_RESULT[3]),
		.rd_addr   (reg_addr[2:0]),
		.side_data (ctrl_read),
		.rd_data   (reg_rdata)
	);

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);

	logic [5:0] conv_age;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			conv_age <= 6'd0;
		end else if (begin_conv || conv_done) begin
			conv_age <= 6'd0;
		end else if (conv_age != 6'h3F) begin
			conv_age <= conv_age + 6'd1;
		end
	end

	sequence done_seq;
		conv_done;
	endsequence

	sequence pulse_seq;
		irq_req ##1 !irq_req;
	endsequence

	conv_len_sh8_a: assert property (conv_done && sample_hold_enable && !resolution_10 |->
		conv_age == 6'd27) else $error("eight-bit sample-hold conversion not 28 cycles");
	conv_len_sh10_a: assert property (conv_done && sample_hold_enable && resolution_10 |->
		conv_age == 6'd32) else $error("ten-bit sample-hold conversion not 33 cycles");
	irq_pulse_a: assert property (done_seq |=> pulse_seq)
		else $error("interrupt request is not a single pulse after completion");
	dma_pair_a: assert property (dma_req |-> irq_req)
		else $error("transfer request without interrupt request");
	dma_dest_a: assert property (conv_done && dma_mode_enable |-> dest_reg == 3'd0 ##1 dma_req)
		else $error("DMA result not in register zero");
	sweep_wrap_a: assert property (conv_done && multiport_sweep_enable &&
		sweep_index == ast_pkg::SWEEP_LAST |=> sweep_index == 4'h0)
		else $error("sweep did not wrap to index zero");
	stop_write_a: assert property (wr_ctrl0 && !reg_wdata[ast_pkg::POS_START] |=> ##1
		state == ast_pkg::ST_IDLE) else $error("conversion did not stop on start clear");
	sw_start_a: assert property (state == ast_pkg::ST_IDLE && conversion_start_bit &&
		!trigger_mode_select |=> state == ast_pkg::ST_CONV)
		else $error("software trigger did not start conversion");
	ext_edge_a: assert property (state == ast_pkg::ST_WAIT && conversion_start_bit &&
		!hardware_trigger_select && $fell(ext_sync) |=> state == ast_pkg::ST_CONV)
		else $error("falling trigger edge did not start conversion");
	timer_start_a: assert property (state == ast_pkg::ST_WAIT && conversion_start_bit &&
		hardware_trigger_select && motor_timer_counter |=> state == ast_pkg::ST_CONV)
		else $error("timer event did not start conversion");
	retrigger_a: assert property (state == ast_pkg::ST_CONV && conversion_start_bit && trig_event
		|=> sweep_index == 4'h0 && conv_age == 6'd0)
		else $error("retrigger did not restart conversion");
	res8_a: assert property (conv_done && !resolution_10 |-> placed_result[9:8] == 2'h0)
		else $error("eight-bit result has upper bits set");

endmodule

// ===== tb/adc_sweep_trigger_control_test.sv
// Self-checking bench of the sweep, trigger and result placement control.
module adc_sweep_trigger_control_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic        sys_clk, reset, reg_wr, reg_rd, ext_trig, timer_evt, dma_on;
	logic        ext_drive, converting, irq_req, dma_req;
	logic [3:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic [9:0]  core_result;
	logic [1:0]  input_source, input_group, grp;
	logic [2:0]  input_channel;
	logic [6:0]  exp_q[$];
	integer      miscompares = 0, checks_done = 0, seed = 61, irqs = 0, n, i;

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	ast_sweep_trigger_control DUT (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.external_trigger_input(ext_trig), .motor_timer_counter(timer_evt),
		.core_result(core_result), .input_source(input_source), .input_group(input_group),
		.input_channel(input_channel), .extended_input_zero_drive(ext_drive),
		.converting(converting), .irq_req(irq_req), .dma_req(dma_req));

	ast_core_model core (.input_source(input_source), .input_group(input_group),
		.input_channel(input_channel), .extended_input_zero_drive(ext_drive),
		.core_result(core_result));

	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic summarize();
		$display("Checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Outputs are sampled before the edge's updates land, so routing is that of the
	// conversion whose completion raised the request.
	always @(posedge sys_clk) begin
		if (irq_req === 1'b1) begin
			irqs++;
			if (exp_q.size() > 0)
				check({9'h0, input_source, input_group, input_channel},
					{9'h0, exp_q.pop_front()}, "routing");
		end
		if (reset === 1'b0)
			check({15'h0, dma_req}, {15'h0, irq_req === 1'b1 && dma_on}, "dma request");
	end

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
		@(posedge sys_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 check(reg_rdata, exp, "register read");
	endtask

	task automatic wait_irq(output integer cyc);
		cyc = 0;
		do begin
			@(posedge sys_clk);
			#1 cyc++;
		end while (irq_req !== 1'b1 && cyc < 200);
		check(16'(cyc < 200), 16'h1, "completion");
	endtask

	task automatic wait_conv();
		integer k;
		for (k = 0; k < 8 && converting !== 1'b1; k++) begin
			@(posedge sys_clk);
			#1;
		end
		check({15'h0, converting}, 16'h1, "trigger start");
	endtask

	// Software-started one-shot of a random channel; dst below zero means its own register.
	task automatic one_shot(input logic r10, input logic [1:0] ext, input logic dma,
			input logic [1:0] src, input integer dst);
		logic [2:0] c;
		logic [9:0] v;
		c = 3'($random(seed));
		v = {src, 2'h0, c, ~c};
		wr(ast_pkg::OFF_CTRL1, {13'h0, ext, r10});
		wr(ast_pkg::OFF_CTRL3, {15'h0, dma});
		dma_on = dma;
		exp_q.push_back({src, 2'h0, c});
		wr(ast_pkg::OFF_CTRL0, {10'h0, c, 3'h1});
		@(posedge sys_clk);
		#1 check({15'h0, converting}, 16'h1, "software start");
		wait_irq(n);
		check(16'(n), 16'(r10 ? ast_pkg::CYC_SH_10 : ast_pkg::CYC_SH_8), "length");
		check({15'h0, ext_drive}, {15'h0, ext == ast_pkg::EXT_OPAMP}, "op-amp drive");
		rd_chk(ast_pkg::OFF_RESULT + 4'(dst < 0 ? c : dst), r10 ? {6'h0, v} : {8'h0, v[9:2]});
		rd_chk(ast_pkg::OFF_CTRL0, {10'h0, c, 3'h0});
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	initial begin
		reset = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0;
		ext_trig = 1'b1;
		timer_evt = 1'b0;
		dma_on = 1'b0;
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		for (i = 0; i < 7; i++)
			rd_chk(4'(i), 16'h0);
		wr(4'h6, 16'hFFFF);
		rd_chk(4'h6, 16'h0);
		// Sample-hold is chosen before any start, as software must.
		wr(ast_pkg::OFF_CTRL2, 16'h0001);
		one_shot(1'b1, ast_pkg::EXT_NONE, 1'b0, ast_pkg::SRC_MAIN, -1);
		one_shot(1'b0, ast_pkg::EXT_NONE, 1'b0, ast_pkg::SRC_MAIN, -1);
		one_shot(1'b1, ast_pkg::EXT_ZERO, 1'b0, ast_pkg::SRC_EXT0, 0);
		one_shot(1'b1, ast_pkg::EXT_ONE, 1'b0, ast_pkg::SRC_EXT1, 1);
		one_shot(1'b0, ast_pkg::EXT_ONE, 1'b1, ast_pkg::SRC_EXT1, 0);
		one_shot(1'b1, ast_pkg::EXT_OPAMP, 1'b0, ast_pkg::SRC_EXT1, -1);
		grp = 2'($unsigned($random(seed)) % 3);
		wr(ast_pkg::OFF_CTRL1, 16'h0001);
		wr(ast_pkg::OFF_CTRL3, 16'h0003);
		dma_on = 1'b1;
		wr(ast_pkg::OFF_CTRL4, {14'h0, grp});
		for (i = 0; i < 17; i++)
			exp_q.push_back({i[3] ? ast_pkg::SRC_SECOND : ast_pkg::SRC_MAIN, grp, 3'(i)});
		wr(ast_pkg::OFF_CTRL0, 16'h0005);
		for (i = 0; i < 17; i++)
			wait_irq(n);
		wr(ast_pkg::OFF_CTRL0, 16'h0000);
		n = irqs;
		repeat (60) @(posedge sys_clk);
		check(16'(irqs - n), 16'h0, "sweep stopped");
		check(16'(exp_q.size()), 16'h0, "sweep count");
		wr(ast_pkg::OFF_CTRL3, 16'h0000);
		dma_on = 1'b0;
		rd_chk(ast_pkg::OFF_RESULT, {6'h0, ast_pkg::SRC_MAIN, grp, 3'h0, 3'h7});
		wr(ast_pkg::OFF_CTRL1, 16'h0000);
		// Plain repeat of channel 5 converts it again and again into its own register.
		for (i = 0; i < 2; i++)
			exp_q.push_back({ast_pkg::SRC_MAIN, 2'h0, 3'h5});
		wr(ast_pkg::OFF_CTRL0, 16'h002D);
		wait_irq(n);
		wait_irq(n);
		check(16'(n), 16'(ast_pkg::CYC_SH_8), "repeat length");
		wr(ast_pkg::OFF_CTRL0, 16'h0000);
		rd_chk(ast_pkg::OFF_RESULT + 4'h5, 16'h000A);
		check(16'(exp_q.size()), 16'h0, "repeat count");
		exp_q.push_back({ast_pkg::SRC_MAIN, 2'h0, 3'h0});
		wr(ast_pkg::OFF_CTRL0, 16'h0003);
		repeat (20) @(posedge sys_clk);
		#1 check({15'h0, converting}, 16'h0, "armed idle");
		@(posedge sys_clk);
		ext_trig <= 1'b0;
		wait_conv();
		repeat (10) @(posedge sys_clk);
		ext_trig <= 1'b1;
		repeat (4) @(posedge sys_clk);
		ext_trig <= 1'b0;
		wait_irq(n);
		check(16'(n > 25), 16'h1, "retrigger restart");
		@(posedge sys_clk);
		ext_trig <= 1'b1;
		wr(ast_pkg::OFF_CTRL2, 16'h0003);
		exp_q.push_back({ast_pkg::SRC_MAIN, 2'h0, 3'h0});
		wr(ast_pkg::OFF_CTRL0, 16'h0003);
		repeat (5) @(posedge sys_clk);
		#1 check({15'h0, converting}, 16'h0, "armed idle");
		@(posedge sys_clk);
		timer_evt <= 1'b1;
		@(posedge sys_clk);
		timer_evt <= 1'b0;
		wait_conv();
		wait_irq(n);
		summarize();
	end

	// The whole run takes some 1,100 cycles; this limit of 20,000 leaves ample margin.
	initial begin
		#200000;
		miscompares++;
		summarize();
	end
endmodule

// ===== tb/ast_core_model.sv
// Behavioural analog multiplexer and converter core facing the sweep control.
module ast_core_model (
	// Routing from the control
	input  wire logic [1:0] input_source,
	input  wire logic [1:0] input_group,
	input  wire logic [2:0] input_channel,
	input  wire logic       extended_input_zero_drive,
	// Converted value
	output logic      [9:0] core_result
);
	timeunit 1ns;
	timeprecision 1ps;
	// Every routed pin carries a level that names it, so a misrouted sample cannot pass.
	// In op-amp mode the level returned on extended input one names that input and the routed channel.
	always_comb begin
		core_result = {input_source, input_group, input_channel, ~input_channel};
	end
endmodule
